// ---- dma_gcs_pkg.sv ----
// Package with register map, field positions and reset values of the DMA global control block
package dma_gcs_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses, low 16 bits)
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_GLOBAL_CONTROL = 16'h8000;
  localparam logic [15:0] OFS_GLOBAL_STATUS  = 16'h8010;
  localparam logic [15:0] OFS_LAST_ADDRESS   = 16'h8020;
  localparam logic [15:0] OFS_CH3_CELL_SIZE  = 16'h8c30;
  localparam logic [15:0] OFS_CH3_CELL_PTR   = 16'h8c40;
  localparam logic [15:0] OFS_CH3_PATTERN    = 16'h8c50;
  // Alias selectors in address bits 3:2
  localparam logic [1:0]  ALIAS_PLAIN = 2'h0;
  localparam logic [1:0]  ALIAS_CLR   = 2'h1;
  localparam logic [1:0]  ALIAS_SET   = 2'h2;
  localparam logic [1:0]  ALIAS_INV   = 2'h3;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ON_BIT      = 15;
  localparam int CTRL_SUSPEND_BIT = 12;
  localparam int CTRL_BUSY_BIT    = 11;
  localparam int STAT_DIR_BIT     = 3;
  localparam int STAT_CH_MSB      = 2;
  localparam int CELL_SIZE_W      = 16;
  localparam int PATTERN_W        = 8;
  // Writable bit masks
  localparam logic [31:0] CTRL_WMASK = 32'h0000_9000;
  localparam logic [31:0] SIZE_WMASK = 32'h0000_ffff;
  localparam logic [31:0] PAT_WMASK  = 32'h0000_00ff;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_CH   = 3'h0;
endpackage

// ---- dma_gcs_if.sv ----
// Interface carrying bus-access reports and control between the DMA global block parts
`timescale 1ns/1ns
interface dma_gcs_if;
  logic        acc_valid;
  logic        acc_read;
  logic [2:0]  acc_ch;
  logic [31:0] acc_addr;
  logic        enable;
  logic        suspend;
  logic        grant;
  // Grant is made by the gate and only read by the control side
  modport ctrl (input acc_valid, acc_read, acc_ch, acc_addr, grant, output enable, suspend);
  modport gate (output acc_valid, acc_read, acc_ch, acc_addr, grant, input enable, suspend);
  modport rec  (input acc_valid, acc_read, acc_ch, acc_addr);
endinterface

// ---- dma_access_record.sv ----
// Recorder of direction, channel and address of the latest DMA bus access
`timescale 1ns/1ns
module dma_access_record
  import dma_gcs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Access reports
  dma_gcs_if.rec           acc,
  // Recorded state
  output logic             o_last_read,
  output logic [2:0]       o_last_ch,
  output logic [31:0]      o_last_addr
);
  // ---------------------------------------------------------------
  // Capture on every performed access
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_last_read <= 1'b0;
      o_last_ch   <= RST_CH;
      o_last_addr <= RST_WORD;
    end else if (acc.acc_valid) begin
      o_last_read <= acc.acc_read;
      o_last_ch   <= acc.acc_ch;
      o_last_addr <= acc.acc_addr;
    end
  end
endmodule

// ---- dma_bus_gate.sv ----
// Gate that passes channel bus requests only while the controller is enabled and not suspended
`timescale 1ns/1ns
module dma_bus_gate
  import dma_gcs_pkg::*;
(
  // Channel engine request
  input  wire logic        i_req,
  input  wire logic        i_req_read,
  input  wire logic [2:0]  i_req_ch,
  input  wire logic [31:0] i_req_addr,
  input  wire logic        i_bus_done,
  // Gated report
  dma_gcs_if.gate          g
);
  // ---------------------------------------------------------------
  // Issue qualification
  // ---------------------------------------------------------------
  // Suspend and disable both hold off issue; the engine keeps its request pending
  assign g.grant     = i_req & g.enable & ~g.suspend;
  assign g.acc_valid = g.grant & i_bus_done;
  assign g.acc_read  = i_req_read;
  assign g.acc_ch    = i_req_ch;
  assign g.acc_addr  = i_req_addr;
endmodule

// ---- dma_global_control_status.sv ----
// DMA global control, status and last-access observation registers
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module dma_global_control_status
  import dma_gcs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // Channel engine bus request
  input  wire logic        i_req,
  input  wire logic        i_req_read,
  input  wire logic [2:0]  i_req_ch,
  input  wire logic [31:0] i_req_addr,
  input  wire logic        i_bus_done,
  input  wire logic [15:0] i_ch3_cell_ptr,
  // Controls to the engines
  output logic             o_grant,
  output logic             o_enable,
  output logic             o_suspend,
  output logic             o_busy
);
  // ---------------------------------------------------------------
  // Local state
  // ---------------------------------------------------------------
  dma_gcs_if link ();

  logic        on_r;
  logic        suspend_r;
  logic [15:0] cell_size_r;
  logic [7:0]  pattern_r;
  logic        last_read;
  logic [2:0]  last_ch;
  logic [31:0] last_addr;
  logic        busy;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic [15:0] base_addr  = {i_reg_addr[15:4], 4'h0};
  wire logic [1:0]  alias_sel  = i_reg_addr[3:2];
  wire logic        sel_ctrl   = (base_addr == OFS_GLOBAL_CONTROL);
  wire logic        sel_stat   = (base_addr == OFS_GLOBAL_STATUS);
  wire logic        sel_addr   = (base_addr == OFS_LAST_ADDRESS);
  wire logic        sel_size   = (base_addr == OFS_CH3_CELL_SIZE);
  wire logic        sel_ptr    = (base_addr == OFS_CH3_CELL_PTR);
  wire logic        sel_pat    = (base_addr == OFS_CH3_PATTERN);

  // Atomic alias arithmetic, shared by all writable registers
  function automatic logic [31:0] alias_apply(input logic [31:0] cur,
                                              input logic [31:0] wd,
                                              input logic [1:0]  sel,
                                              input logic [31:0] wmask);
    logic [31:0] res;
    res = cur;
    unique case (sel)
      ALIAS_PLAIN: res = wd;
      ALIAS_CLR:   res = cur & ~wd;
      ALIAS_SET:   res = cur | wd;
      ALIAS_INV:   res = cur ^ wd;
    endcase
    return (res & wmask) | (cur & ~wmask);
  endfunction

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  wire logic [31:0] ctrl_cur = {16'h0000, on_r, 2'b00, suspend_r, 12'h000};
  wire logic [31:0] ctrl_new = alias_apply(ctrl_cur, i_reg_wdata, alias_sel, CTRL_WMASK);
  wire logic [31:0] size_new = alias_apply({16'h0000, cell_size_r}, i_reg_wdata,
                                           alias_sel, SIZE_WMASK);
  wire logic [31:0] pat_new  = alias_apply({24'h00_0000, pattern_r}, i_reg_wdata,
                                           alias_sel, PAT_WMASK);

  wire logic on_nxt      = (i_reg_wr && sel_ctrl) ? ctrl_new[CTRL_ON_BIT] : on_r;
  wire logic suspend_nxt = (i_reg_wr && sel_ctrl) ? ctrl_new[CTRL_SUSPEND_BIT] : suspend_r;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      on_r        <= 1'b0;
      suspend_r   <= 1'b0;
      cell_size_r <= RST_WORD[15:0];
      pattern_r   <= RST_WORD[7:0];
    end else begin
      on_r      <= on_nxt;
      suspend_r <= suspend_nxt;
      if (i_reg_wr && sel_size) begin
        cell_size_r <= size_new[CELL_SIZE_W-1:0];
      end
      if (i_reg_wr && sel_pat) begin
        pattern_r <= pat_new[PATTERN_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Issue gating and access recording
  // ---------------------------------------------------------------
  assign link.enable  = on_r;
  assign link.suspend = suspend_r;

  dma_bus_gate u_gate (
    .i_req      (i_req),
    .i_req_read (i_req_read),
    .i_req_ch   (i_req_ch),
    .i_req_addr (i_req_addr),
    .i_bus_done (i_bus_done),
    .g          (link.gate)
  );

  dma_access_record u_rec (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .acc         (link.rec),
    .o_last_read (last_read),
    .o_last_ch   (last_ch),
    .o_last_addr (last_addr)
  );

  // Busy covers an enabled controller only; the grant term needs enable, so an access in flight adds nothing
  assign busy      = on_r | link.grant;
  assign o_grant   = link.grant;
  assign o_enable  = on_r;
  assign o_suspend = suspend_r;
  assign o_busy    = busy;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Busy is hardware-owned: writes to its bit are masked off above
  wire logic [31:0] ctrl_rd = ctrl_cur | ({31'h0, busy} << CTRL_BUSY_BIT);
  wire logic [31:0] stat_rd = {28'h000_0000, last_read, last_ch};
  wire logic [31:0] rd_mux  = sel_ctrl ? ctrl_rd :
                              sel_stat ? stat_rd :
                              sel_addr ? last_addr :
                              sel_size ? {16'h0000, cell_size_r} :
                              sel_ptr  ? {16'h0000, i_ch3_cell_ptr} :
                              sel_pat  ? {24'h00_0000, pattern_r} :
                              RST_WORD;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= RST_WORD;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end else begin
      o_reg_rdata <= RST_WORD;
    end
  end
endmodule

// ---- dma_gcs_monitor.sv ----
// Checker of register and access behaviour at the DMA global block ports
`timescale 1ns/1ns
module dma_gcs_monitor
  import dma_gcs_pkg::*;
(
  // Clock, reset and register port
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [31:0] o_reg_rdata,
  // Access path and controls
  input  wire logic        i_req,
  input  wire logic        i_req_read,
  input  wire logic [2:0]  i_req_ch,
  input  wire logic [31:0] i_req_addr,
  input  wire logic        i_bus_done,
  input  wire logic        o_grant,
  input  wire logic        o_enable,
  input  wire logic        o_suspend,
  input  wire logic        o_busy
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic taken = o_grant && i_bus_done;
  wire logic ctl_wr = i_reg_wr && (i_reg_addr[15:4] == OFS_GLOBAL_CONTROL[15:4]);
  chk_grant_gate: assert property (o_grant == (i_req && o_enable && !o_suspend))
    else $error("grant does not follow request, enable and suspend");
  chk_busy_level: assert property (o_busy == (o_enable || o_grant))
    else $error("busy flag wrong");
  chk_status_upper: assert property (i_reg_rd && i_reg_addr == OFS_GLOBAL_STATUS
    |=> o_reg_rdata[31:4] == 28'h0) else $error("status upper bits not zero");
  // A read one idle cycle after an access must show that access
  chk_status_record: assert property (taken ##1 !taken
    ##1 (i_reg_rd && i_reg_addr == OFS_GLOBAL_STATUS)
    |=> o_reg_rdata[3:0] == {$past(i_req_read, 3), $past(i_req_ch, 3)})
    else $error("status does not hold last access");
  chk_addr_record: assert property (taken ##1 !taken
    ##1 (i_reg_rd && i_reg_addr == OFS_LAST_ADDRESS)
    |=> o_reg_rdata == $past(i_req_addr, 3)) else $error("address record wrong");
  chk_set_enable: assert property (ctl_wr && i_reg_addr[3:2] == ALIAS_SET && i_reg_wdata[15]
    |=> o_enable) else $error("set alias did not enable");
  chk_clr_enable: assert property (ctl_wr && i_reg_addr[3:2] == ALIAS_CLR && i_reg_wdata[15]
    |=> !o_enable && !o_busy) else $error("clear alias did not disable");
  chk_inv_suspend: assert property (ctl_wr && i_reg_addr[3:2] == ALIAS_INV && i_reg_wdata[12]
    |=> o_suspend != $past(o_suspend)) else $error("invert alias did not toggle suspend");
  chk_ctrl_read: assert property (i_reg_rd && i_reg_addr == OFS_GLOBAL_CONTROL
    |=> o_reg_rdata == {16'h0, $past(o_enable), 2'h0, $past(o_suspend), $past(o_busy), 11'h0})
    else $error("control read value wrong");
endmodule
bind dma_global_control_status dma_gcs_monitor mon (.i_core_clk, .i_rst, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_req, .i_req_read, .i_req_ch,
  .i_req_addr, .i_bus_done, .o_grant, .o_enable, .o_suspend, .o_busy);

// ---- dma_engine_model.sv ----
// Behavioural channel engine that asks for bus accesses and waits for the grant
`timescale 1ns/1ns
module dma_engine_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_grant,
  output logic             o_req,
  output logic             o_req_read,
  output logic [2:0]       o_req_ch,
  output logic [31:0]      o_req_addr,
  output logic             o_bus_done
);
  initial begin
    o_req = 1'b0;
    o_req_read = 1'b0;
    o_req_ch = 3'h0;
    o_req_addr = 32'h0000_0000;
    o_bus_done = 1'b0;
  end
  // Request held until granted and done; gives up after maxw edges
  task automatic access(input logic rd, input logic [2:0] ch, input logic [31:0] a,
                        input int lat, input int maxw);
    int n;
    int w;
    n = 0;
    w = 0;
    @(posedge i_core_clk);
    o_req <= 1'b1;
    o_req_read <= rd;
    o_req_ch <= ch;
    o_req_addr <= a;
    o_bus_done <= (lat == 0);
    do begin
      @(posedge i_core_clk);
      w++;
      if (i_grant && o_bus_done) break;
      if (i_grant) begin
        n++;
        o_bus_done <= (n >= lat);
      end
    end while (w < maxw);
    // Released lines show the inverse so stale values cannot pass
    o_req <= 1'b0;
    o_bus_done <= 1'b0;
    o_req_read <= ~rd;
    o_req_ch <= ~ch;
    o_req_addr <= ~a;
  endtask
endmodule

// ---- testbench.sv ----
// Register and access tests of the DMA global control and status block
`timescale 1ns/1ns
module testbench
  import dma_gcs_pkg::*;
;
  logic        i_core_clk, i_rst, i_reg_wr, i_reg_rd, req, req_read, bus_done;
  logic [15:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, req_addr;
  logic [2:0]  req_ch;
  logic        o_grant, o_enable, o_suspend, o_busy;
  int          bad_count = 0;
  int          checked = 0;
  localparam logic [15:0] C = OFS_GLOBAL_CONTROL;
  localparam logic [15:0] S = OFS_GLOBAL_STATUS;
  localparam logic [15:0] A = OFS_LAST_ADDRESS;
  dma_global_control_status dut (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_req(req), .i_req_read(req_read), .i_req_ch(req_ch),
    .i_req_addr(req_addr), .i_bus_done(bus_done), .i_ch3_cell_ptr(16'h1234), .o_grant,
    .o_enable, .o_suspend, .o_busy);
  dma_engine_model eng (.i_core_clk, .i_grant(o_grant), .o_req(req), .o_req_read(req_read),
    .o_req_ch(req_ch), .o_req_addr(req_addr), .o_bus_done(bus_done));
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 check(o_reg_rdata, exp);
  endtask
  task automatic test_done;
    $display("Mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Run needs about a hundred cycles; far more means a hang
  initial begin
    repeat (5000) @(posedge i_core_clk);
    bad_count++;
    test_done;
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {1'b1, 50'h0};
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(C, 32'h0);
    rd(S, 32'h0);
    rd(A, 32'h0);
    wr(C, 32'hffff_ffff);
    rd(C, 32'h0000_9800);
    wr(C | 16'hc, 32'h0000_1000);
    rd(C, 32'h0000_8800);
    wr(C | 16'h4, 32'h0000_8000);
    rd(C, 32'h0);
    wr(C | 16'h8, 32'h0000_8000);
    rd(C | 16'h8, 32'h0000_8800);
    wr(OFS_CH3_CELL_SIZE, 32'hffff_ffff);
    rd(OFS_CH3_CELL_SIZE, 32'h0000_ffff);
    wr(OFS_CH3_PATTERN | 16'h8, 32'h0000_0181);
    rd(OFS_CH3_PATTERN, 32'h0000_0081);
    wr(OFS_CH3_CELL_PTR, 32'hffff_ffff);
    rd(OFS_CH3_CELL_PTR, 32'h0000_1234);
    wr(S, 32'hffff_ffff);
    rd(S, 32'h0);
    wr(A, 32'hffff_ffff);
    rd(A, 32'h0);
    rd(16'h9000, 32'h0);
    eng.access(1'b1, 3'h5, 32'ha5a5_0004, 0, 20);
    rd(S, 32'h0000_000d);
    rd(A, 32'ha5a5_0004);
    eng.access(1'b0, 3'h2, 32'h0000_7ffc, 3, 20);
    rd(S, 32'h0000_0002);
    rd(A, 32'h0000_7ffc);
    wr(C | 16'h8, 32'h0000_1000);
    fork
      eng.access(1'b1, 3'h7, 32'h8000_0000, 1, 40);
      begin
        repeat (6) @(posedge i_core_clk);
        check(o_grant, 32'h0);
        check(o_suspend, 32'h1);
        wr(C | 16'h4, 32'h0000_1000);
      end
    join
    rd(S, 32'h0000_000f);
    rd(A, 32'h8000_0000);
    wr(C | 16'h4, 32'h0000_8000);
    #1 check(o_busy, 32'h0);
    check(o_enable, 32'h0);
    eng.access(1'b0, 3'h1, 32'h1111_0000, 0, 10);
    rd(S, 32'h0000_000f);
    rd(A, 32'h8000_0000);
    test_done;
  end
endmodule
